// ---- rtl/standby_pkg.sv ----
// Package: standby control constants and types
package standby_pkg;
  // Configuration register of the runtime logical device
  localparam logic [7:0] SLOW_CLOCK_CONFIG_OFFSET = 8'hF0;
  localparam int ABSENT_BIT = 0;
  localparam logic [7:0] SLOW_CLOCK_CONFIG_RESET = 8'h00;
  localparam logic [3:0] RUNTIME_DEVICE = 4'hA;
  // Supply threshold in millivolts
  localparam int MAIN_SUPPLY_GOOD_MV = 2300;
  // Slow clock, reference clock and system clock rates
  localparam int SLOW_CLOCK_HZ = 32768;
  localparam int REF_CLOCK_HZ = 14318180;
  localparam int CLOCK_HZ = 125000000;
  // Half period of internal slow clock in ref clock cycles
  localparam int REF_HALF_CYCLES = REF_CLOCK_HZ / (2 * 32000);
  localparam logic [8:0] REF_HALF_COUNT = 9'(REF_HALF_CYCLES - 1);

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] device;
    logic [7:0] offset;
    logic [7:0] data;
  } cfg_req_t;
endpackage

// ---- rtl/slow_clock_divider.sv ----
// Internal slow clock level derived from the reference clock
`timescale 1ns/100ps
module slow_clock_divider
  import standby_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Reference clock, already synchronised
  input wire logic ref_clock_i,
  // Derived slow clock level
  output logic slow_clock_o
);
  logic ref_prev_reg;
  logic [8:0] count_reg;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ref_prev_reg <= 1'b0;
    end else begin
      ref_prev_reg <= ref_clock_i;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= 9'h000;
      slow_clock_o <= 1'b0;
    end else if (ref_clock_i && !ref_prev_reg) begin
      if (count_reg == REF_HALF_COUNT) begin
        count_reg <= 9'h000;
        slow_clock_o <= !slow_clock_o;
      end else begin
        count_reg <= count_reg + 9'h001;
      end
    end
  end
endmodule

// ---- rtl/standby_power_and_slow_clock_select.sv ----
// Standby power gating and slow clock source select
// Notes on behaviour
// RULE_01: Host reads and writes decoded only while main supply is good.
// RULE_02: Wake output and wake inputs keep working on trickle supply.
// RULE_03: IR transmit and indicator pins stay under logic control on trickle.
// RULE_04: Main supply low disables the IR half-duplex timeout.
// RULE_05: Trickle power-on reset initialises IR, wake config and wake logic.
// RULE_06: Absent flag is bit 0 at 0xF0, cleared by trickle reset or a host write, not by main supply loss.
// RULE_07: Flag 0 means external slow clock present; 1 means pin grounded.
// RULE_08: Flag 0 selects external slow clock; 1 selects divided reference.
// RULE_09: Internal slow clock works while main supply is present.
// RULE_10: Software sets the flag when no external slow clock is fitted.
`timescale 1ns/100ps
module standby_power_and_slow_clock_select
  import standby_pkg::*;
(
  // Clock and trickle power-on reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Supply status and clock pins
  input wire logic main_supply_good_i,
  input wire logic slow_clock_pin_i,
  input wire logic ref_clock_i,
  // Configuration access
  input wire cfg_req_t cfg_req_i,
  output logic [7:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  // Wake inputs from pins
  input wire logic keyboard_data_pin_i,
  input wire logic mouse_data_pin_i,
  input wire logic infrared_receive_pin_i,
  input wire logic ring_input_first_n_i,
  input wire logic ring_input_second_n_i,
  input wire logic second_serial_receive_i,
  // Wake inputs qualified for the wake logic
  output logic [5:0] wake_inputs_o,
  input wire logic wake_event_n_i,
  output logic wake_event_out_n_o,
  // Transmit and indicator drive
  input wire logic infrared_transmit_i,
  input wire logic second_serial_transmit_i,
  input wire logic indicator_one_i,
  input wire logic indicator_two_i,
  output logic infrared_transmit_pin_o,
  output logic second_serial_transmit_o,
  output logic indicator_one_o,
  output logic indicator_two_o,
  // Control to neighbouring blocks
  output logic host_decode_enable_o,
  output logic ir_timeout_enable_o,
  output logic slow_clock_o,
  output logic slow_clock_absent_o
);
  // Ring inputs are active low, the rest active high
  localparam int WAKE_COUNT = 6;
  localparam logic [5:0] WAKE_ACTIVE_LOW = 6'h18;

  logic [1:0] good_sync_reg;
  logic [1:0] pin_sync_reg;
  logic [1:0] ref_sync_reg;
  logic [5:0] wake_pins;
  logic [7:0] config_reg;
  logic internal_slow;
  logic good;
  logic host_access;
  logic read_hit;
  logic write_hit;

  // Supply good synchroniser
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      good_sync_reg <= 2'h0;
    end else begin
      good_sync_reg <= {good_sync_reg[0], main_supply_good_i};
    end
  end

  // Slow clock pin synchroniser
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pin_sync_reg <= 2'h0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], slow_clock_pin_i};
    end
  end

  // Reference clock synchroniser
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ref_sync_reg <= 2'h0;
    end else begin
      ref_sync_reg <= {ref_sync_reg[0], ref_clock_i};
    end
  end

  assign good = good_sync_reg[1];

  // RULE_02: wake pins gathered
  assign wake_pins = {second_serial_receive_i, ring_input_second_n_i,
    ring_input_first_n_i, infrared_receive_pin_i, mouse_data_pin_i,
    keyboard_data_pin_i};

  // RULE_02: per pin sync, polarity after sync
  for (genvar b = 0; b < WAKE_COUNT; b++) begin : g_wake
    logic [1:0] sync_reg;

    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        sync_reg <= {2{WAKE_ACTIVE_LOW[b]}};
      end else begin
        sync_reg <= {sync_reg[0], wake_pins[b]};
      end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        wake_inputs_o[b] <= 1'b0;
      end else begin
        wake_inputs_o[b] <= sync_reg[1] ^ WAKE_ACTIVE_LOW[b];
      end
    end
  end

  // RULE_02: wake output independent of supply
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wake_event_out_n_o <= 1'b1;
    end else begin
      wake_event_out_n_o <= wake_event_n_i;
    end
  end

  // RULE_03: transmit and indicators follow logic
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      infrared_transmit_pin_o <= 1'b0;
      second_serial_transmit_o <= 1'b0;
      indicator_one_o <= 1'b0;
      indicator_two_o <= 1'b0;
    end else begin
      infrared_transmit_pin_o <= infrared_transmit_i;
      second_serial_transmit_o <= second_serial_transmit_i;
      indicator_one_o <= indicator_one_i;
      indicator_two_o <= indicator_two_i;
    end
  end

  // RULE_01: gate host decode on supply
  assign host_access = good && cfg_req_i.device == RUNTIME_DEVICE
    && cfg_req_i.offset == SLOW_CLOCK_CONFIG_OFFSET;
  assign read_hit = host_access && cfg_req_i.rd;
  assign write_hit = host_access && cfg_req_i.wr;

  // RULE_05: trickle reset clears configuration
  // RULE_06: flag held at bit 0 of 0xF0
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      config_reg <= SLOW_CLOCK_CONFIG_RESET;
    end else if (write_hit) begin
      config_reg <= cfg_req_i.data;
    end
  end

  // RULE_01: read strobe only when powered
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rvalid_o <= read_hit;
    end
  end

  // RULE_01: read data, zero when idle
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_rdata_o <= 8'h00;
    end else begin
      cfg_rdata_o <= read_hit ? config_reg : 8'h00;
    end
  end

  // RULE_09: internal clock from reference
  slow_clock_divider divider (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ref_clock_i(ref_sync_reg[1]),
    .slow_clock_o(internal_slow)
  );

  // RULE_07: flag encoding of clock source
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      slow_clock_absent_o <= 1'b0;
    end else begin
      slow_clock_absent_o <= config_reg[ABSENT_BIT];
    end
  end

  // RULE_08: slow clock source select
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      slow_clock_o <= 1'b0;
    end else begin
      slow_clock_o <= config_reg[ABSENT_BIT] ? internal_slow
        : pin_sync_reg[1];
    end
  end

  // RULE_01: host decode enable output
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      host_decode_enable_o <= 1'b0;
    end else begin
      host_decode_enable_o <= good;
    end
  end

  // RULE_04: IR timeout off while supply low
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ir_timeout_enable_o <= 1'b0;
    end else begin
      ir_timeout_enable_o <= good;
    end
  end
endmodule

// ---- tb/standby_properties.sv ----
// Checker for standby control ports
`timescale 1ns/100ps
module standby_properties
  import standby_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic main_supply_good_i,
  input wire logic slow_clock_pin_i,
  input wire cfg_req_t cfg_req_i,
  input wire logic cfg_rvalid_o,
  input wire logic wake_event_n_i,
  input wire logic wake_event_out_n_o,
  input wire logic infrared_transmit_i,
  input wire logic infrared_transmit_pin_o,
  input wire logic ir_timeout_enable_o,
  input wire logic slow_clock_o,
  input wire logic slow_clock_absent_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic hit;
  assign hit = cfg_req_i.device == RUNTIME_DEVICE &&
    cfg_req_i.offset == SLOW_CLOCK_CONFIG_OFFSET;
  property p_gate;
    !main_supply_good_i [*3] ##0 cfg_req_i.rd |=> !cfg_rvalid_o;
  endproperty
  a_gate: assert property (p_gate) else $error("read answered");
  property p_read;
    main_supply_good_i [*4] ##0 (cfg_req_i.rd && hit) |=> cfg_rvalid_o;
  endproperty
  a_read: assert property (p_read) else $error("read lost");
  property p_pulse;
    cfg_rvalid_o |-> $past(cfg_req_i.rd);
  endproperty
  a_pulse: assert property (p_pulse) else $error("stray valid");
  property p_tout;
    !main_supply_good_i [*4] |-> !ir_timeout_enable_o;
  endproperty
  a_tout: assert property (p_tout) else $error("timeout on");
  property p_absent;
    main_supply_good_i [*4] ##0 (cfg_req_i.wr && hit) ##1 !cfg_req_i.wr
      |=> slow_clock_absent_o == $past(cfg_req_i.data[0], 2);
  endproperty
  a_absent: assert property (p_absent) else $error("flag wrong");
  property p_hold;
    !main_supply_good_i [*5] |=> $stable(slow_clock_absent_o);
  endproperty
  a_hold: assert property (p_hold) else $error("flag moved");
  property p_ext;
    (slow_clock_pin_i && !slow_clock_absent_o) [*5] |-> slow_clock_o;
  endproperty
  a_ext: assert property (p_ext) else $error("pin not used");
  property p_tx;
    !$past(rst_i) |-> infrared_transmit_pin_o == $past(infrared_transmit_i);
  endproperty
  a_tx: assert property (p_tx) else $error("tx lost");
  property p_wake;
    !$past(rst_i) |-> wake_event_out_n_o == $past(wake_event_n_i);
  endproperty
  a_wake: assert property (p_wake) else $error("wake lost");
endmodule
bind standby_power_and_slow_clock_select standby_properties u_props (
  .clock_i, .rst_i, .main_supply_good_i, .slow_clock_pin_i, .cfg_req_i,
  .cfg_rvalid_o, .wake_event_n_i, .wake_event_out_n_o, .infrared_transmit_i,
  .infrared_transmit_pin_o, .ir_timeout_enable_o, .slow_clock_o,
  .slow_clock_absent_o);

// ---- tb/standby_power_and_slow_clock_select_tb.sv ----
// Bench for standby control
`timescale 1ns/100ps
module standby_power_and_slow_clock_select_tb;
  import standby_pkg::*;
  logic clock_i = 0, rst_i = 1, good = 0, pin = 0, refc = 0, wen = 1;
  logic rv, wev, hde, ite, sco, sca;
  logic [7:0] rd;
  logic [5:0] wi = 0, wo;
  logic [3:0] tx = 0;
  wire [3:0] txo;
  cfg_req_t req = '0;
  int n_mismatch = 0, cmp_count = 0;
  standby_power_and_slow_clock_select dut (.clock_i, .rst_i,
    .main_supply_good_i(good), .slow_clock_pin_i(pin), .ref_clock_i(refc),
    .cfg_req_i(req), .cfg_rdata_o(rd), .cfg_rvalid_o(rv),
    .keyboard_data_pin_i(wi[0]), .mouse_data_pin_i(wi[1]),
    .infrared_receive_pin_i(wi[2]), .ring_input_first_n_i(wi[3]),
    .ring_input_second_n_i(wi[4]), .second_serial_receive_i(wi[5]),
    .wake_inputs_o(wo), .wake_event_n_i(wen), .wake_event_out_n_o(wev),
    .infrared_transmit_i(tx[0]), .second_serial_transmit_i(tx[1]),
    .indicator_one_i(tx[2]), .indicator_two_i(tx[3]),
    .infrared_transmit_pin_o(txo[0]), .second_serial_transmit_o(txo[1]),
    .indicator_one_o(txo[2]), .indicator_two_o(txo[3]),
    .host_decode_enable_o(hde), .ir_timeout_enable_o(ite),
    .slow_clock_o(sco), .slow_clock_absent_o(sca));
  initial forever #4 clock_i = ~clock_i;
  always #35 refc = ~refc;
  task give_verdict;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [7:0] g, e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task op(input logic w, r, input logic [7:0] o, d,
    input logic [3:0] v = 4'hA);
    @(negedge clock_i);
    req = '{w, r, v, o, d};
    @(negedge clock_i);
    req = '0;
  endtask
  task rdchk(input logic [7:0] e);
    op(0, 1, 8'hF0, 8'h00);
    chk(rv, 8'h01);
    chk(rd, e);
  endtask
  task t_low;
    good = 0;
    wi = 6'h2A;
    tx = 4'hA;
    wen = 0;
    op(1, 0, 8'hF0, 8'h01);
    op(0, 1, 8'hF0, 8'h00);
    chk(rv, 8'h00);
    repeat (4) @(negedge clock_i);
    chk({hde, ite, sca, wev}, 8'h00);
    chk(wo, 8'h32);
    chk(txo, 8'h0A);
  endtask
  task t_reg;
    good = 1;
    repeat (4) @(negedge clock_i);
    rdchk(8'h00);
    op(1, 0, 8'hF1, 8'hFF);
    op(1, 0, 8'hF0, 8'hFF, 4'h9);
    rdchk(8'h00);
    op(1, 0, 8'hF0, 8'hFF);
    rdchk(8'hFF);
    chk({sca, hde, ite}, 8'h07);
    good = 0;
    repeat (6) @(negedge clock_i);
    good = 1;
    repeat (4) @(negedge clock_i);
    rdchk(8'hFF);
  endtask
  task t_clk;
    int n;
    logic s;
    for (int i = 0; i < 2; i++) begin
      s = sco;
      n = 0;
      while (sco === s && n < 600) begin
        @(posedge refc);
        n++;
      end
    end
    chk(8'(n >= 222 && n <= 226), 8'h01);
    op(1, 0, 8'hF0, 8'h00);
    pin = 1;
    repeat (5) @(negedge clock_i);
    chk({sca, sco}, 8'h01);
    pin = 0;
    repeat (5) @(negedge clock_i);
    chk(sco, 8'h00);
  endtask
  task t_rst;
    op(1, 0, 8'hF0, 8'h01);
    @(negedge clock_i);
    chk(sca, 8'h01);
    rst_i = 1;
    @(negedge clock_i);
    rst_i = 0;
    chk({sca, sco, hde, wev}, 8'h01);
    repeat (4) @(negedge clock_i);
    rdchk(8'h00);
  endtask
  initial begin
    repeat (4) @(posedge clock_i);
    @(negedge clock_i);
    rst_i = 0;
    chk({sca, wev}, 8'h01);
    t_low;
    t_reg;
    t_clk;
    t_rst;
    give_verdict;
  end
  initial begin
    #200000;
    n_mismatch++;
    give_verdict;
  end
endmodule
